// file: design/phys_request_filter_high.sv
// Upper physical request filter: register bank and receive routing verdict.
// Assumes the receive path presents one request per cycle with its async
// filter result, and that software reaches the bank over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "prfh_consts.svh"

module phys_request_filter_high (
	// Clock and resets
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic                       host_port_reset,
	// Avalon-MM slave
	input  wire logic [`PRFH_ADDR_W-1:0]    avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [`PRFH_DATA_W-1:0]    avs_writedata,
	input  wire logic [`PRFH_BE_W-1:0]      avs_byteenable,
	output var  logic [`PRFH_DATA_W-1:0]    avs_readdata,
	output logic                            avs_waitrequest,
	// Link identity
	input  wire logic [`PRFH_BUS_W-1:0]     local_bus_id,
	// Incoming request
	input  wire prfh_pkg::prfh_pkt_req_t    pkt_req,
	// Routing verdict
	output prfh_pkg::prfh_route_t           route,
	output logic                            accept_all_remote_buses
);

	typedef struct packed {
		prfh_pkg::prfh_route_t      route;
		logic [`PRFH_CNT_W-1:0]     phys_count;
		logic [`PRFH_CNT_W-1:0]     async_count;
	} prfh_top_state_t;

	prfh_top_state_t                state;
	prfh_top_state_t                next_state;
	prfh_pkg::prfh_reg_wr_t         reg_wr;
	logic [`PRFH_ADDR_W-1:0]        reg_rd_addr;
	logic [`PRFH_DATA_W-1:0]        reg_rd_data;
	logic [`PRFH_DATA_W-1:0]        filter;
	logic                           set_stb;
	logic                           clr_stb;
	logic                           cnt_clr;
	logic                           src_local;
	logic                           node_in_range;
	logic [`PRFH_NODE_W-1:0]        node_index;
	logic                           node_enabled;
	logic                           verdict_ack;
	logic                           verdict_phys;
	logic                           verdict_async;
	logic                           verdict_handled;

	// Address hit test, used by the strobes and the read mux
	function automatic logic addr_is(
		input logic [`PRFH_ADDR_W-1:0] addr,
		input logic [`PRFH_ADDR_W-1:0] ofs
	);
		addr_is = (addr == ofs);
	endfunction

	prfh_avmm_slave u_slave (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.reg_wr          (reg_wr),
		.reg_rd_addr     (reg_rd_addr),
		.reg_rd_data     (reg_rd_data)
	);

	assign set_stb = reg_wr.wr && addr_is(reg_wr.addr, `PRFH_OFS_SET);
	assign clr_stb = reg_wr.wr && addr_is(reg_wr.addr, `PRFH_OFS_CLEAR);
	assign cnt_clr = reg_wr.wr && addr_is(reg_wr.addr, `PRFH_OFS_COUNT);

	// Zero bits of the write data leave their filter bits alone
	prfh_setclr_reg #(
		.WIDTH     (`PRFH_DATA_W),
		.RST_VALUE (`PRFH_FILTER_RST),
		.KEEP_MASK (`PRFH_KEEP_MASK)
	) u_filter (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.host_port_reset (host_port_reset),
		.set_stb         (set_stb),
		.clr_stb         (clr_stb),
		.wdata           (reg_wr.data),
		.value           (filter)
	);

	assign accept_all_remote_buses = filter[`PRFH_ALL_BUSES_BIT];

	// Read mux; unmapped offsets read zero
	always_comb begin
		reg_rd_data = `PRFH_WORD_ZERO;
		if (addr_is(reg_rd_addr, `PRFH_OFS_SET) ||
			addr_is(reg_rd_addr, `PRFH_OFS_CLEAR)) begin
			reg_rd_data = filter;
		end else if (addr_is(reg_rd_addr, `PRFH_OFS_STATUS)) begin
			reg_rd_data = {{(`PRFH_DATA_W-`PRFH_NODE_W-5){1'b0}},
				state.route.src_node,
				state.route.async_ctx,
				state.route.phys_ctx,
				state.route.ack,
				state.route.handled,
				state.route.valid};
		end else if (addr_is(reg_rd_addr, `PRFH_OFS_COUNT)) begin
			reg_rd_data = {state.async_count, state.phys_count};
		end
	end

	// Source classification
	assign src_local = (pkt_req.src_bus == local_bus_id) ||
		(pkt_req.src_bus == `PRFH_LOCAL_ALIAS);
	assign node_in_range = (pkt_req.src_node >= `PRFH_NODE_BASE) &&
		(pkt_req.src_node <= `PRFH_NODE_LAST);
	assign node_index = pkt_req.src_node - `PRFH_NODE_BASE;
	assign node_enabled = filter[node_index[`PRFH_NODE_W-2:0]];

	always_comb begin
		verdict_handled = 1'b0;
		verdict_ack     = 1'b0;
		verdict_phys    = 1'b0;
		verdict_async   = 1'b0;
		if (!src_local) begin
			verdict_handled = 1'b1;
			verdict_ack     = accept_all_remote_buses;
			verdict_phys    = accept_all_remote_buses && pkt_req.to_phys;
			verdict_async   = accept_all_remote_buses && !pkt_req.to_phys;
		end else if (node_in_range) begin
			verdict_handled = 1'b1;
			verdict_ack     = pkt_req.async_accept;
			if (pkt_req.async_accept) begin
				if (pkt_req.to_phys && node_enabled) begin
					verdict_phys = 1'b1;
				end else begin
					verdict_async = 1'b1;
				end
			end
		end
	end

	always_comb begin
		next_state                = state;
		next_state.route.valid    = pkt_req.valid;
		next_state.route.handled  = pkt_req.valid && verdict_handled;
		next_state.route.ack      = pkt_req.valid && verdict_ack;
		next_state.route.phys_ctx = pkt_req.valid && verdict_phys;
		next_state.route.async_ctx = pkt_req.valid && verdict_async;
		next_state.route.src_node = pkt_req.src_node;
		// A count in the same cycle as a clear is kept: that counter restarts at one
		if (cnt_clr) begin
			next_state.phys_count  = `PRFH_CNT_ZERO;
			next_state.async_count = `PRFH_CNT_ZERO;
		end
		if (pkt_req.valid && verdict_phys) begin
			next_state.phys_count = (cnt_clr ? `PRFH_CNT_ZERO : state.phys_count)
				+ `PRFH_CNT_ONE;
		end
		if (pkt_req.valid && verdict_async) begin
			next_state.async_count = (cnt_clr ? `PRFH_CNT_ZERO : state.async_count)
				+ `PRFH_CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state.route       <= '0;
			state.route.src_node <= `PRFH_NODE_ZERO;
			state.phys_count  <= `PRFH_CNT_ZERO;
			state.async_count <= `PRFH_CNT_ZERO;
		end else begin
			state <= next_state;
		end
	end

	assign route = state.route;

endmodule
`default_nettype wire

// file: design/prfh_avmm_slave.sv
// Avalon-MM slave front end with waitrequest for the filter registers.
// Assumes the owner decodes addresses and supplies read data combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "prfh_consts.svh"

module prfh_avmm_slave (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	// Avalon-MM slave
	input  wire logic [`PRFH_ADDR_W-1:0]    avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [`PRFH_DATA_W-1:0]    avs_writedata,
	input  wire logic [`PRFH_BE_W-1:0]      avs_byteenable,
	output var  logic [`PRFH_DATA_W-1:0]    avs_readdata,
	output logic                            avs_waitrequest,
	// Register side
	output prfh_pkg::prfh_reg_wr_t          reg_wr,
	output logic [`PRFH_ADDR_W-1:0]         reg_rd_addr,
	input  wire logic [`PRFH_DATA_W-1:0]    reg_rd_data
);

	typedef struct packed {
		prfh_pkg::prfh_bus_state_t  st;
		logic [`PRFH_DATA_W-1:0]    rdata;
	} prfh_slv_state_t;

	prfh_slv_state_t             state;
	prfh_slv_state_t             next_state;
	logic [`PRFH_DATA_W-1:0]     lane_mask;

	// Byte enables widened to a bit mask
	genvar b;
	generate
		for (b = 0; b < `PRFH_BE_W; b++) begin : g_lane
			assign lane_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
		end
	endgenerate

	always_comb begin
		next_state = state;
		unique case (state.st)
			prfh_pkg::PRFH_IDLE: begin
				if (avs_read || avs_write) begin
					next_state.st = prfh_pkg::PRFH_ACK;
				end
				next_state.rdata = avs_read ? reg_rd_data : `PRFH_WORD_ZERO;
			end
			prfh_pkg::PRFH_ACK: begin
				next_state.st = prfh_pkg::PRFH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= '{st: prfh_pkg::PRFH_IDLE, rdata: `PRFH_WORD_ZERO};
		end else begin
			state <= next_state;
		end
	end

	// Answer one cycle after the request is seen; writes land on the edge that ends that cycle
	assign avs_waitrequest = (state.st != prfh_pkg::PRFH_ACK);
	assign avs_readdata    = state.rdata;
	assign reg_rd_addr     = avs_address;
	assign reg_wr.wr       = (state.st == prfh_pkg::PRFH_ACK) && avs_write;
	assign reg_wr.addr     = avs_address;
	assign reg_wr.data     = avs_writedata & lane_mask;

endmodule
`default_nettype wire

// file: design/prfh_consts.svh
// Constants of the upper physical request filter: offsets, fields, resets.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef PRFH_CONSTS_SVH
`define PRFH_CONSTS_SVH

`define PRFH_DATA_W        32
`define PRFH_ADDR_W        9
`define PRFH_BE_W          4
`define PRFH_BUS_W         10
`define PRFH_NODE_W        6
`define PRFH_CNT_W         16

`define PRFH_OFS_SET       9'h110
`define PRFH_OFS_CLEAR     9'h114
`define PRFH_OFS_STATUS    9'h128
`define PRFH_OFS_COUNT     9'h12C

`define PRFH_FILTER_RST    32'h0000_0000
`define PRFH_KEEP_MASK     32'h8000_0000
`define PRFH_ALL_BUSES_BIT 31
`define PRFH_NODE_BASE     6'h20
`define PRFH_NODE_LAST     6'h3E
`define PRFH_LOCAL_ALIAS   10'h3FF
`define PRFH_WORD_ZERO     32'h0000_0000
`define PRFH_CNT_ZERO      16'h0000
`define PRFH_CNT_ONE       16'h0001
`define PRFH_NODE_ZERO     6'h00

`endif

// file: design/prfh_pkg.sv
// Types shared by the upper physical request filter modules.
// Assumes prfh_consts.svh on the include path.
`include "prfh_consts.svh"

package prfh_pkg;

	typedef enum logic [0:0] {
		PRFH_IDLE = 1'b0,
		PRFH_ACK  = 1'b1
	} prfh_bus_state_t;

	// Register write after byte lane masking
	typedef struct packed {
		logic                       wr;
		logic [`PRFH_ADDR_W-1:0]    addr;
		logic [`PRFH_DATA_W-1:0]    data;
	} prfh_reg_wr_t;

	// Request as seen by the receive path
	typedef struct packed {
		logic                       valid;
		logic                       to_phys;
		logic                       async_accept;
		logic [`PRFH_BUS_W-1:0]     src_bus;
		logic [`PRFH_NODE_W-1:0]    src_node;
	} prfh_pkt_req_t;

	// Routing verdict
	typedef struct packed {
		logic                       valid;
		logic                       handled;
		logic                       ack;
		logic                       phys_ctx;
		logic                       async_ctx;
		logic [`PRFH_NODE_W-1:0]    src_node;
	} prfh_route_t;

endpackage

// file: design/prfh_setclr_reg.sv
// Set/clear register: ones set or clear bits, zeros leave them alone.
// Assumes set and clear strobes come from distinct addresses.
`timescale 1ns/10ps
`default_nettype none
`include "prfh_consts.svh"

module prfh_setclr_reg #(
	parameter int                  WIDTH     = `PRFH_DATA_W,
	parameter logic [WIDTH-1:0]    RST_VALUE = `PRFH_FILTER_RST,
	parameter logic [WIDTH-1:0]    KEEP_MASK = `PRFH_KEEP_MASK
) (
	// Clock and resets
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                host_port_reset,
	// Software access
	input  wire logic                set_stb,
	input  wire logic                clr_stb,
	input  wire logic [WIDTH-1:0]    wdata,
	// Contents
	output logic [WIDTH-1:0]         value
);

	typedef struct packed {
		logic [WIDTH-1:0]  bits;
	} prfh_scr_state_t;

	prfh_scr_state_t    state;
	prfh_scr_state_t    next_state;
	logic [WIDTH-1:0]   next_bits;

	// Host port reset spares kept bits; a set in the same cycle wins
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign next_bits[i] = (set_stb && wdata[i]) ? 1'b1 :
				((clr_stb && wdata[i]) ? 1'b0 :
				((host_port_reset && !KEEP_MASK[i]) ? RST_VALUE[i] : state.bits[i]));
		end
	endgenerate

	always_comb begin
		next_state      = state;
		next_state.bits = next_bits;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state.bits <= RST_VALUE;
		end else begin
			state <= next_state;
		end
	end

	assign value = state.bits;

endmodule
`default_nettype wire

// file: dv/phys_request_filter_high_tb.sv
// Self-checking bench of the upper physical request filter.
// Assumes the design, its package and the remote node model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "prfh_consts.svh"
module phys_request_filter_high_tb;
	logic sys_clk = 0, rst_n = 0, host_port_reset = 0, avs_read = 0, avs_write = 0;
	logic [8:0]  avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_waitrequest, accept_all_remote_buses;
	logic [9:0]  local_bus_id = 10'h005;
	prfh_pkg::prfh_pkt_req_t cmd = '0, pkt_req;
	prfh_pkg::prfh_route_t   route;
	int n_fail = 0, checks_done = 0;
	always #2 sys_clk = ~sys_clk;
	phys_request_filter_high uut (.sys_clk, .rst_n, .host_port_reset, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .local_bus_id, .pkt_req, .route, .accept_all_remote_buses);
	prfh_remote_node u_node (.sys_clk, .cmd, .pkt_req);
	task automatic chk32(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_route(input prfh_pkg::prfh_route_t exp);
		checks_done++;
		if (route !== exp) begin
			n_fail++;
			$display("MISMATCH route expected %h seen %h", exp, route);
		end
	endtask
	task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		@(negedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 20) n_fail++;
		rd = avs_readdata;
		@(posedge sys_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Expected flags: handled, ack, physical context, async context
	task automatic send(input logic [9:0] b, input logic [5:0] node, input logic tp, aa,
		input logic [3:0] hapq);
		@(posedge sys_clk);
		cmd <= {1'b1, tp, aa, b, node};
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk_route({1'b1, hapq, node});
	endtask
	task automatic t_regs;
		bus(1'b0, `PRFH_OFS_SET, 32'h0, 4'hF);
		chk32("reset value", 32'h0, rd);
		bus(1'b1, `PRFH_OFS_SET, 32'hA000_0005, 4'hF);
		bus(1'b1, `PRFH_OFS_CLEAR, 32'h0000_0001, 4'hF);
		bus(1'b0, `PRFH_OFS_CLEAR, 32'h0, 4'hF);
		chk32("set then clear", 32'hA000_0004, rd);
		bus(1'b1, `PRFH_OFS_CLEAR, 32'hFFFF_FFFF, 4'h7);
		bus(1'b0, `PRFH_OFS_SET, 32'h0, 4'hF);
		chk32("lane masked clear", 32'hA000_0000, rd);
		bus(1'b0, 9'h100, 32'h0, 4'hF);
		chk32("unmapped read", 32'h0, rd);
	endtask
	task automatic t_remote;
		bus(1'b1, `PRFH_OFS_CLEAR, 32'h8000_0000, 4'hF);
		send(10'h009, 6'h21, 1'b1, 1'b1, 4'b1000);
		bus(1'b1, `PRFH_OFS_SET, 32'h8000_0000, 4'hF);
		bus(1'b1, `PRFH_OFS_COUNT, 32'h0, 4'hF);
		send(10'h009, 6'h21, 1'b1, 1'b0, 4'b1110);
		send(10'h009, 6'h02, 1'b0, 1'b0, 4'b1101);
		bus(1'b0, `PRFH_OFS_COUNT, 32'h0, 4'hF);
		chk32("context counts", 32'h0001_0001, rd);
	endtask
	task automatic t_nodes;
		for (int n = 32; n <= 62; n++) begin
			bus(1'b1, `PRFH_OFS_CLEAR, 32'h7FFF_FFFF, 4'hF);
			bus(1'b1, `PRFH_OFS_SET, 32'h1 << (n - 32), 4'hF);
			send(local_bus_id, 6'(n), 1'b1, 1'b1, 4'b1110);
			send(10'h3FF, 6'(n == 62 ? 61 : n + 1), 1'b1, 1'b1, 4'b1101);
		end
		send(local_bus_id, 6'h3E, 1'b1, 1'b0, 4'b1000);
		send(local_bus_id, 6'h3E, 1'b0, 1'b1, 4'b1101);
		send(local_bus_id, 6'h1F, 1'b1, 1'b1, 4'b0000);
		send(local_bus_id, 6'h3F, 1'b1, 1'b1, 4'b0000);
	endtask
	task automatic t_host_reset;
		bus(1'b1, `PRFH_OFS_SET, 32'hFFFF_FFFF, 4'hF);
		@(posedge sys_clk);
		host_port_reset <= 1'b1;
		@(posedge sys_clk);
		host_port_reset <= 1'b0;
		bus(1'b0, `PRFH_OFS_CLEAR, 32'h0, 4'hF);
		chk32("after host reset", 32'h8000_0000, rd);
		chk32("flag pin", 32'h1, {31'h0, accept_all_remote_buses});
	endtask
	task automatic final_report;
		$display("Checks done %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_remote();
		t_nodes();
		t_host_reset();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire

// file: dv/prfh_assertions.sv
// Checker of the upper physical request filter, watching top-level ports only.
// Assumes it is bound into phys_request_filter_high.
`timescale 1ns/10ps
`default_nettype none
`include "prfh_consts.svh"
module prfh_assertions (
	// Clock and resets
	input wire logic                    sys_clk,
	input wire logic                    rst_n,
	input wire logic                    host_port_reset,
	// Avalon-MM
	input wire logic [`PRFH_ADDR_W-1:0] avs_address,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [`PRFH_DATA_W-1:0] avs_writedata,
	input wire logic [`PRFH_BE_W-1:0]   avs_byteenable,
	input wire logic                    avs_waitrequest,
	// Routing
	input wire logic [`PRFH_BUS_W-1:0]  local_bus_id,
	input wire prfh_pkg::prfh_pkt_req_t pkt_req,
	input wire prfh_pkg::prfh_route_t   route,
	input wire logic                    accept_all_remote_buses
);
	logic flag, remote, local_hi, wr31;
	assign flag = accept_all_remote_buses;
	assign remote = pkt_req.valid && pkt_req.src_bus != local_bus_id
		&& pkt_req.src_bus != `PRFH_LOCAL_ALIAS;
	assign local_hi = pkt_req.valid && !remote && pkt_req.src_node >= `PRFH_NODE_BASE
		&& pkt_req.src_node <= `PRFH_NODE_LAST;
	assign wr31 = avs_write && !avs_waitrequest && avs_byteenable[3] && avs_writedata[31];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_lat;
		pkt_req.valid |=> route.valid && route.src_node == $past(pkt_req.src_node);
	endproperty
	property p_rem_off;
		remote && !flag |=> !route.ack && !route.phys_ctx && !route.async_ctx;
	endproperty
	property p_rem_on;
		remote && flag |=> route.ack && route.phys_ctx == $past(pkt_req.to_phys)
			&& route.async_ctx != $past(pkt_req.to_phys);
	endproperty
	property p_gate;
		local_hi && !pkt_req.async_accept |=> !route.ack && !route.phys_ctx && !route.async_ctx;
	endproperty
	property p_one_ctx;
		local_hi && pkt_req.async_accept |=> route.ack && route.phys_ctx != route.async_ctx
			&& (!route.phys_ctx || $past(pkt_req.to_phys));
	endproperty
	property p_range;
		pkt_req.valid && !remote && !local_hi |=> !route.handled && !route.ack;
	endproperty
	property p_set;
		wr31 && avs_address == `PRFH_OFS_SET |=> flag;
	endproperty
	property p_clr;
		wr31 && avs_address == `PRFH_OFS_CLEAR |=> !flag;
	endproperty
	property p_keep;
		avs_write && !avs_waitrequest && !wr31 |=> $stable(flag);
	endproperty
	property p_hpr;
		host_port_reset && avs_waitrequest |=> $stable(flag);
	endproperty
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_lat: assert property (p_lat) else $error("route latency wrong");
	a_rem_off: assert property (p_rem_off) else $error("remote acked");
	a_rem_on: assert property (p_rem_on) else $error("remote refused");
	a_gate: assert property (p_gate) else $error("async gate open");
	a_one_ctx: assert property (p_one_ctx) else $error("context choice wrong");
	a_range: assert property (p_range) else $error("node range wrong");
	a_set: assert property (p_set) else $error("set failed");
	a_clr: assert property (p_clr) else $error("clear failed");
	a_keep: assert property (p_keep) else $error("zero bit changed flag");
	a_hpr: assert property (p_hpr) else $error("flag lost on host reset");
	a_wait: assert property (p_wait) else $error("wait cycle wrong");
	c_rem: cover property (remote && flag);
	c_phys: cover property (local_hi ##1 route.phys_ctx);
	c_hpr: cover property (host_port_reset && flag);
endmodule
bind phys_request_filter_high prfh_assertions u_chk (.sys_clk, .rst_n, .host_port_reset,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
	.local_bus_id, .pkt_req, .route, .accept_all_remote_buses);
`default_nettype wire

// file: dv/prfh_remote_node.sv
// Remote node model: presents one request per bench command.
// Assumes commands change just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module prfh_remote_node (
	// Clock
	input wire logic                    sys_clk,
	// Command from the bench
	input wire prfh_pkg::prfh_pkt_req_t cmd,
	// Request to the filter
	output var prfh_pkg::prfh_pkt_req_t pkt_req
);
	initial pkt_req = '0;
	// Idle fields toggle so stale values are never trusted
	always @(posedge sys_clk) begin
		pkt_req <= cmd.valid ? cmd : {1'b0, ~pkt_req[$bits(pkt_req)-2:0]};
	end
endmodule
`default_nettype wire
